//--- cal_cfg_pkg.sv
// constants and types shared by the calibration configuration and status block
package cal_cfg_pkg;
    localparam int          ADDR_W          = 8;
    localparam int          DATA_W          = 8;
    // register offsets
    localparam logic [7:0]  OFS_CFG_ZERO    = 8'h62;
    localparam logic [7:0]  OFS_CFG_ONE     = 8'h65;
    localparam logic [7:0]  OFS_AVG         = 8'h68;
    localparam logic [7:0]  OFS_STATE       = 8'h6a;
    localparam logic [7:0]  OFS_CAL_ENABLE  = 8'h61;
    localparam logic [7:0]  OFS_PIN_CFG     = 8'h6b;
    localparam logic [7:0]  OFS_IRQ_STATUS  = 8'h70;
    localparam logic [7:0]  OFS_IRQ_ENABLE  = 8'h71;
    localparam logic [7:0]  OFS_IRQ_CLEAR   = 8'h72;
    localparam logic [7:0]  OFS_STOP_REQ    = 8'h73;
    // reset values
    localparam logic [7:0]  RST_CFG_ZERO    = 8'h01;
    localparam logic [7:0]  RST_CFG_ONE     = 8'h01;
    localparam logic [7:0]  RST_AVG         = 8'h61;
    localparam logic [7:0]  RST_CAL_ENABLE  = 8'h01;
    localparam logic [7:0]  RST_PIN_CFG     = 8'h00;
    // field positions
    localparam int          BIT_FG          = 0;
    localparam int          BIT_BG          = 1;
    localparam int          BIT_OS          = 2;
    localparam int          BIT_BGOS        = 3;
    localparam int          BIT_OFFSET_REFERENCE_SELECT       = 2;
    localparam int          BIT_DONE        = 0;
    localparam int          BIT_STOPPED     = 1;
    localparam int          POS_STAT        = 2;
    localparam int          POS_LIN_AVG     = 0;
    localparam int          POS_OFFSET_AVERAGING_DEPTH      = 4;
    localparam int          POS_PIN_SEL     = 1;
    // status pin selector codes
    localparam logic [1:0]  PIN_SEL_DONE    = 2'h0;
    localparam logic [1:0]  PIN_SEL_STOPPED = 2'h1;
    localparam logic [1:0]  PIN_SEL_ALARM   = 2'h2;
    // interrupt status bits
    localparam int          IRQ_DONE        = 0;
    localparam int          IRQ_STOPPED     = 1;
    // per-step cycle base of one averaging unit
    localparam logic [15:0] STEP_BASE       = 16'h0010;

    typedef enum logic [2:0] {
        ST_HOLD    = 3'b000,
        ST_CLEAR   = 3'b001,
        ST_FG_LIN  = 3'b010,
        ST_FG_OFS  = 3'b011,
        ST_BG_RUN  = 3'b100,
        ST_STOPPED = 3'b101,
        ST_IDLE    = 3'b110
    } cal_state_t;
endpackage

//--- adc_calibration_config_status.sv
// calibration configuration registers, sequencer and status flags
//
// Functional notes
// - fg select clears values, then runs/skips foreground
// - bg select enables background calibration
// - fg offset cal only with fg select
// - bg offset cal only with bg select
// - offset reference zero targets mid-code
// - offset reference one uses spare converter
// - offset averaging depth, reset six
// - linearity averaging depth, reset one
// - stopped flag set when bg halted
// - stopped flag clears when calibration resumes
// - without bg, stopped set after foreground
// - done flag bit zero after foreground
// - status register read-only, reset value zero
// - enable bit runs or holds calibration
// - status pin select routes flag outputs
`timescale 1ns/100ps
`default_nettype none
module adc_calibration_config_status
    import cal_cfg_pkg::*;
(
    input  wire logic                          ref_clk_i,
    input  wire logic                          reset_n_i,
    input  wire logic [cal_cfg_pkg::ADDR_W-1:0] addr_i,
    input  wire logic [cal_cfg_pkg::DATA_W-1:0] wdata_i,
    input  wire logic                          wr_i,
    input  wire logic                          rd_i,
    input  wire logic                          alarm_i,
    output logic      [cal_cfg_pkg::DATA_W-1:0] rdata_o,
    output logic                               calibration_status_pin_o,
    output logic                               irq_o,
    output logic                               cal_running_o,
    output logic                               offset_reference_select_o,
    output logic      [2:0]                    offset_averaging_depth_o,
    output logic      [2:0]                    linearity_averaging_depth_o
);
    import cal_cfg_pkg::*;

    // software registers
    logic [7:0]  calibration_config_zero_r;
    logic [7:0]  calibration_config_zero_nxt;
    logic [7:0]  calibration_config_one_r;
    logic [7:0]  calibration_config_one_nxt;
    logic [7:0]  calibration_averaging_r;
    logic [7:0]  calibration_averaging_nxt;
    logic [7:0]  cal_enable_r;
    logic [7:0]  cal_enable_nxt;
    logic [7:0]  pin_cfg_r;
    logic [7:0]  pin_cfg_nxt;
    logic [1:0]  irq_enable_r;
    logic [1:0]  irq_enable_nxt;
    logic        stop_req_r;
    logic        stop_req_nxt;

    // sequencer state
    cal_state_t  state_r;
    cal_state_t  state_nxt;
    logic [15:0] step_cnt_r;
    logic [15:0] step_cnt_nxt;
    logic        foreground_complete_flag_r;
    logic        foreground_complete_flag_nxt;
    logic        stopped_flag_r;
    logic        stopped_flag_nxt;
    logic [1:0]  irq_status_r;
    logic [1:0]  irq_status_nxt;
    logic [1:0]  irq_event;
    logic [1:0]  irq_clear;

    // outputs
    logic [7:0]  rdata_r;
    logic [7:0]  rdata_nxt;
    logic        pin_r;
    logic        pin_nxt;
    logic        irq_r;
    logic        irq_nxt;
    logic        running_nxt;
    logic        offset_reference_select_nxt;
    logic [2:0]  os_depth_nxt;
    logic [2:0]  lin_depth_nxt;

    // alarm comes from analog domain
    logic        alarm_meta_r;
    logic        alarm_sync_r;

    // decoded fields and sequencer helpers
    logic        background_cal_enable;
    logic        foreground_cal_select;
    logic        fg_offset_cal_enable;
    logic        bg_offset_cal_enable;
    logic [2:0]  os_depth;
    logic [2:0]  lin_depth;
    // longest pass is two depth-seven routines; 16 bits leave headroom
    logic [15:0] lin_len;
    logic [15:0] ofs_len;
    logic [15:0] bg_pass_len;
    logic        pass_end;
    logic [7:0]  state_rd;
    logic        wr_zero;
    logic        wr_one;
    logic        restart;
    logic [1:0]  pin_sel;

    assign foreground_cal_select = calibration_config_zero_r[BIT_FG];
    assign background_cal_enable = calibration_config_zero_r[BIT_BG];
    // offset routines are gated by their parent mode
    assign fg_offset_cal_enable  = calibration_config_zero_r[BIT_OS] & foreground_cal_select;
    assign bg_offset_cal_enable  = calibration_config_zero_r[BIT_BGOS] & background_cal_enable;
    assign os_depth  = calibration_averaging_r[POS_OFFSET_AVERAGING_DEPTH +: 3];
    assign lin_depth = calibration_averaging_r[POS_LIN_AVG +: 3];
    // averaging depth stretches each routine: base shifted by depth
    assign lin_len = STEP_BASE << lin_depth;
    assign ofs_len = STEP_BASE << os_depth;
    // with bg offset cal enabled, an offset pass rides on the tail of each linearity pass
    assign bg_pass_len = bg_offset_cal_enable ? (lin_len + ofs_len) : lin_len;
    assign pass_end    = step_cnt_r >= bg_pass_len - 16'h0001;
    assign wr_zero = wr_i && (addr_i == OFS_CFG_ZERO);
    assign wr_one  = wr_i && (addr_i == OFS_CFG_ONE);
    // stale flags after a settings change would mislead a polling host
    assign restart = wr_zero || wr_one;
    assign pin_sel = pin_cfg_r[POS_PIN_SEL +: 2];

    // no reset: the pair only carries a level and settles in two cycles
    always_ff @(posedge ref_clk_i) begin
        alarm_meta_r <= alarm_i;
        alarm_sync_r <= alarm_meta_r;
    end

    // register writes
    always_comb begin
        calibration_config_zero_nxt = calibration_config_zero_r;
        calibration_config_one_nxt  = calibration_config_one_r;
        calibration_averaging_nxt   = calibration_averaging_r;
        cal_enable_nxt              = cal_enable_r;
        pin_cfg_nxt                 = pin_cfg_r;
        irq_enable_nxt              = irq_enable_r;
        stop_req_nxt                = stop_req_r;
        if (wr_i) begin
            case (addr_i)
                OFS_CFG_ZERO:   calibration_config_zero_nxt = wdata_i;
                OFS_CFG_ONE:    calibration_config_one_nxt  = wdata_i;
                OFS_AVG:        calibration_averaging_nxt   = wdata_i;
                OFS_CAL_ENABLE: cal_enable_nxt              = wdata_i;
                OFS_PIN_CFG:    pin_cfg_nxt                 = wdata_i;
                OFS_IRQ_ENABLE: irq_enable_nxt              = wdata_i[1:0];
                OFS_STOP_REQ:   stop_req_nxt                = wdata_i[0];
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!reset_n_i) begin
            calibration_config_zero_r <= RST_CFG_ZERO;
            calibration_config_one_r  <= RST_CFG_ONE;
            calibration_averaging_r   <= RST_AVG;
            cal_enable_r              <= RST_CAL_ENABLE;
            pin_cfg_r                 <= RST_PIN_CFG;
            irq_enable_r              <= 2'h0;
            stop_req_r                <= 1'b0;
        end else begin
            calibration_config_zero_r <= calibration_config_zero_nxt;
            calibration_config_one_r  <= calibration_config_one_nxt;
            calibration_averaging_r   <= calibration_averaging_nxt;
            cal_enable_r              <= cal_enable_nxt;
            pin_cfg_r                 <= pin_cfg_nxt;
            irq_enable_r              <= irq_enable_nxt;
            stop_req_r                <= stop_req_nxt;
        end
    end

    // sequencer: hold while disabled, clear values, foreground, then background
    always_comb begin
        state_nxt                    = state_r;
        step_cnt_nxt                 = step_cnt_r;
        foreground_complete_flag_nxt = foreground_complete_flag_r;
        stopped_flag_nxt             = stopped_flag_r;
        if (!cal_enable_r[0]) begin
            // held in reset; settings may change safely here
            state_nxt                    = ST_HOLD;
            step_cnt_nxt                 = 16'h0000;
            foreground_complete_flag_nxt = 1'b0;
            stopped_flag_nxt             = 1'b0;
        end else begin
            case (state_r)
                ST_HOLD: begin
                    state_nxt                    = ST_CLEAR;
                    foreground_complete_flag_nxt = 1'b0;
                    stopped_flag_nxt             = 1'b0;
                end
                ST_CLEAR: begin
                    // stored values are wiped whether or not foreground runs
                    step_cnt_nxt = 16'h0000;
                    if (foreground_cal_select) begin
                        state_nxt = ST_FG_LIN;
                    end else begin
                        state_nxt                    = background_cal_enable ? ST_BG_RUN : ST_IDLE;
                        foreground_complete_flag_nxt = 1'b1;
                        stopped_flag_nxt             = !background_cal_enable;
                    end
                end
                ST_FG_LIN: begin
                    step_cnt_nxt = step_cnt_r + 16'h0001;
                    if (step_cnt_r >= lin_len - 16'h0001) begin
                        step_cnt_nxt = 16'h0000;
                        if (fg_offset_cal_enable) begin
                            state_nxt = ST_FG_OFS;
                        end else begin
                            state_nxt                    = background_cal_enable ? ST_BG_RUN : ST_IDLE;
                            foreground_complete_flag_nxt = 1'b1;
                            stopped_flag_nxt             = !background_cal_enable;
                        end
                    end
                end
                ST_FG_OFS: begin
                    step_cnt_nxt = step_cnt_r + 16'h0001;
                    if (step_cnt_r >= ofs_len - 16'h0001) begin
                        step_cnt_nxt                 = 16'h0000;
                        state_nxt                    = background_cal_enable ? ST_BG_RUN : ST_IDLE;
                        foreground_complete_flag_nxt = 1'b1;
                        stopped_flag_nxt             = !background_cal_enable;
                    end
                end
                ST_BG_RUN: begin
                    // phase boundary every linearity pass; offset pass added when enabled
                    step_cnt_nxt = step_cnt_r + 16'h0001;
                    if (!background_cal_enable) begin
                        state_nxt        = ST_IDLE;
                        stopped_flag_nxt = 1'b1;
                    end else if (pass_end) begin
                        step_cnt_nxt = 16'h0000;
                        if (stop_req_r) begin
                            state_nxt        = ST_STOPPED;
                            stopped_flag_nxt = 1'b1;
                        end
                    end
                end
                ST_STOPPED: begin
                    if (!stop_req_r || !background_cal_enable) begin
                        state_nxt        = background_cal_enable ? ST_BG_RUN : ST_IDLE;
                        step_cnt_nxt     = 16'h0000;
                        stopped_flag_nxt = !background_cal_enable;
                    end
                end
                ST_IDLE: begin
                    if (background_cal_enable) begin
                        state_nxt        = ST_BG_RUN;
                        step_cnt_nxt     = 16'h0000;
                        stopped_flag_nxt = 1'b0;
                    end
                end
                default: begin
                    state_nxt = ST_HOLD;
                end
            endcase
            // a fresh configuration write restarts the whole sequence
            if (restart) begin
                state_nxt                    = ST_HOLD;
                foreground_complete_flag_nxt = 1'b0;
                stopped_flag_nxt             = 1'b0;
            end
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!reset_n_i) begin
            state_r                    <= ST_HOLD;
            step_cnt_r                 <= 16'h0000;
            foreground_complete_flag_r <= 1'b0;
            stopped_flag_r             <= 1'b0;
        end else begin
            state_r                    <= state_nxt;
            step_cnt_r                 <= step_cnt_nxt;
            foreground_complete_flag_r <= foreground_complete_flag_nxt;
            stopped_flag_r             <= stopped_flag_nxt;
        end
    end

    // read path, status pin and interrupt
    always_comb begin
        state_rd                 = 8'h00;
        state_rd[BIT_DONE]       = foreground_complete_flag_r;
        state_rd[BIT_STOPPED]    = stopped_flag_r;
        state_rd[POS_STAT +: 3]  = state_r;
        rdata_nxt = 8'h00;
        if (rd_i) begin
            case (addr_i)
                OFS_CFG_ZERO:   rdata_nxt = calibration_config_zero_r;
                OFS_CFG_ONE:    rdata_nxt = calibration_config_one_r;
                OFS_AVG:        rdata_nxt = calibration_averaging_r;
                OFS_STATE:      rdata_nxt = state_rd;
                OFS_CAL_ENABLE: rdata_nxt = cal_enable_r;
                OFS_PIN_CFG:    rdata_nxt = pin_cfg_r;
                OFS_IRQ_STATUS: rdata_nxt = {6'h00, irq_status_r};
                OFS_IRQ_ENABLE: rdata_nxt = {6'h00, irq_enable_r};
                OFS_STOP_REQ:   rdata_nxt = {7'h00, stop_req_r};
                default:        rdata_nxt = 8'h00;
            endcase
        end
    end

    always_comb begin
        case (pin_sel)
            PIN_SEL_DONE:    pin_nxt = foreground_complete_flag_nxt;
            PIN_SEL_STOPPED: pin_nxt = stopped_flag_nxt;
            PIN_SEL_ALARM:   pin_nxt = alarm_sync_r;
            default:         pin_nxt = 1'b0;
        endcase
        // rising edges of the flags feed the sticky bits
        irq_event              = 2'h0;
        irq_event[IRQ_DONE]    = foreground_complete_flag_nxt && !foreground_complete_flag_r;
        irq_event[IRQ_STOPPED] = stopped_flag_nxt && !stopped_flag_r;
        irq_clear              = 2'h0;
        if (wr_i && addr_i == OFS_IRQ_CLEAR) begin
            irq_clear = wdata_i[1:0];
        end
    end

    // one sticky bit per event; a set beats a same-cycle clear
    for (genvar i = 0; i < 2; i++) begin : g_sticky
        assign irq_status_nxt[i] = irq_event[i] | (irq_status_r[i] & ~irq_clear[i]);
    end
    assign irq_nxt = |(irq_status_nxt & irq_enable_nxt);

    always_ff @(posedge ref_clk_i) begin
        if (!reset_n_i) begin
            rdata_r      <= 8'h00;
            pin_r        <= 1'b0;
            irq_status_r <= 2'h0;
            irq_r        <= 1'b0;
        end else begin
            rdata_r      <= rdata_nxt;
            pin_r        <= pin_nxt;
            irq_status_r <= irq_status_nxt;
            irq_r        <= irq_nxt;
        end
    end

    // configuration fields reach the analog engine straight from registers
    always_comb begin
        // running marks the states in which the analog engine is busy
        running_nxt   = (state_nxt == ST_FG_LIN) || (state_nxt == ST_FG_OFS)
                        || (state_nxt == ST_BG_RUN);
        // 0 = mid-code target, 1 = spare converter; only sane with background on
        offset_reference_select_nxt     = calibration_config_one_nxt[BIT_OFFSET_REFERENCE_SELECT];
        os_depth_nxt  = calibration_averaging_nxt[POS_OFFSET_AVERAGING_DEPTH +: 3];
        lin_depth_nxt = calibration_averaging_nxt[POS_LIN_AVG +: 3];
    end

    always_ff @(posedge ref_clk_i) begin
        if (!reset_n_i) begin
            cal_running_o               <= 1'b0;
            offset_reference_select_o   <= RST_CFG_ONE[BIT_OFFSET_REFERENCE_SELECT];
            offset_averaging_depth_o    <= RST_AVG[POS_OFFSET_AVERAGING_DEPTH +: 3];
            linearity_averaging_depth_o <= RST_AVG[POS_LIN_AVG +: 3];
        end else begin
            cal_running_o               <= running_nxt;
            offset_reference_select_o   <= offset_reference_select_nxt;
            offset_averaging_depth_o    <= os_depth_nxt;
            linearity_averaging_depth_o <= lin_depth_nxt;
        end
    end

    assign rdata_o                  = rdata_r;
    assign calibration_status_pin_o = pin_r;
    assign irq_o                    = irq_r;
endmodule
`default_nettype wire

//--- adc_calibration_config_status_properties.sv
// assertion checker for the calibration configuration and status block
`timescale 1ns/100ps
`default_nettype none
module adc_calibration_config_status_properties
    import cal_cfg_pkg::*;
(
    input wire logic                            ref_clk_i,
    input wire logic                            reset_n_i,
    input wire logic [cal_cfg_pkg::ADDR_W-1:0] addr_i,
    input wire logic [cal_cfg_pkg::DATA_W-1:0] wdata_i,
    input wire logic                            wr_i,
    input wire logic                            rd_i,
    input wire logic                            alarm_i,
    input wire logic [cal_cfg_pkg::DATA_W-1:0] rdata_o,
    input wire logic                            calibration_status_pin_o,
    input wire logic                            irq_o,
    input wire logic                            cal_running_o,
    input wire logic                            offset_reference_select_o,
    input wire logic [2:0]                      offset_averaging_depth_o,
    input wire logic [2:0]                      linearity_averaging_depth_o
);
    import cal_cfg_pkg::*;
    // shadows of pin select and irq enable, not visible at the ports
    logic [1:0] sel_r;
    logic [1:0] sel_nxt;
    logic [1:0] en_r;
    logic [1:0] en_nxt;
    always_comb begin
        sel_nxt = sel_r;
        en_nxt  = en_r;
        if (wr_i && addr_i == OFS_PIN_CFG) begin
            sel_nxt = wdata_i[2:1];
        end
        if (wr_i && addr_i == OFS_IRQ_ENABLE) begin
            en_nxt = wdata_i[1:0];
        end
        if (!reset_n_i) begin
            sel_nxt = 2'h0;
            en_nxt  = 2'h0;
        end
    end
    always_ff @(posedge ref_clk_i) begin
        sel_r <= sel_nxt;
        en_r  <= en_nxt;
    end
    default clocking dclk @(posedge ref_clk_i); endclocking
    default disable iff (!reset_n_i);
    a_depth_reset: assert property ($rose(reset_n_i) |-> offset_averaging_depth_o == 3'h6
        && linearity_averaging_depth_o == 3'h1) else $error("depth reset values wrong");
    a_avg_write: assert property (wr_i && addr_i == OFS_AVG |=>
        {offset_averaging_depth_o, linearity_averaging_depth_o}
        == {$past(wdata_i[6:4]), $past(wdata_i[2:0])}) else $error("depth not updated");
    a_offset_reference_select_write: assert property (wr_i && addr_i == OFS_CFG_ONE |=>
        offset_reference_select_o == $past(wdata_i[2])) else $error("offset_reference_select not updated");
    a_offset_reference_select_reset: assert property ($rose(reset_n_i) |-> !offset_reference_select_o)
        else $error("offset_reference_select not zero after reset");
    a_hold_on_disable: assert property (wr_i && addr_i == OFS_CAL_ENABLE && !wdata_i[0]
        |-> ##[1:2] !cal_running_o) else $error("calibration not held");
    a_restart_clear: assert property (wr_i && addr_i == OFS_CFG_ZERO
        |-> ##[1:3] !cal_running_o) else $error("no restart after config write");
    a_pin_forced_low: assert property (sel_r == 2'h3 && $past(sel_r) == 2'h3
        |-> !calibration_status_pin_o) else $error("status pin not low");
    a_irq_masked: assert property (en_r == 2'h0 && $past(en_r) == 2'h0 |-> !irq_o)
        else $error("irq while masked");
    a_read_only_slot: assert property (rdata_o != 8'h00 |-> $past(rd_i))
        else $error("read data outside read slot");
    c_irq: cover property ($rose(irq_o));
    c_pin: cover property ($rose(calibration_status_pin_o));
    c_run: cover property ($fell(cal_running_o));
endmodule
bind adc_calibration_config_status adc_calibration_config_status_properties i_props (
    .ref_clk_i, .reset_n_i, .addr_i, .wdata_i, .wr_i, .rd_i, .alarm_i, .rdata_o,
    .calibration_status_pin_o, .irq_o, .cal_running_o, .offset_reference_select_o,
    .offset_averaging_depth_o, .linearity_averaging_depth_o
);
`default_nettype wire

//--- adc_calibration_config_status_tb.sv
// self-checking testbench for the calibration configuration and status block
`timescale 1ns/100ps
`default_nettype none
module adc_calibration_config_status_tb;
    import cal_cfg_pkg::*;
    logic       clk   = 1'b0;
    logic       rst_n = 1'b0;
    logic [7:0] addr  = 8'h00;
    logic [7:0] wdat  = 8'h00;
    logic       wr    = 1'b0;
    logic       rd    = 1'b0;
    logic       alarm = 1'b0;
    logic [7:0] rdat;
    logic       pin, irq, run, offset_reference_select;
    logic [2:0] os_d, lin_d;
    logic [7:0] d;
    int         err_count = 0;
    int         checks    = 0;
    always #5 clk = ~clk;
    adc_calibration_config_status i_dut (
        .ref_clk_i(clk), .reset_n_i(rst_n), .addr_i(addr), .wdata_i(wdat), .wr_i(wr),
        .rd_i(rd), .alarm_i(alarm), .rdata_o(rdat), .calibration_status_pin_o(pin),
        .irq_o(irq), .cal_running_o(run), .offset_reference_select_o(offset_reference_select),
        .offset_averaging_depth_o(os_d), .linearity_averaging_depth_o(lin_d)
    );
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        checks++;
        if (g !== e) begin
            err_count++;
            $display("BAD %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic wreg(input logic [7:0] a, input logic [7:0] v);
        @(posedge clk);
        addr <= a;
        wdat <= v;
        wr   <= 1'b1;
        @(posedge clk);
        wr   <= 1'b0;
        // outputs launched at the write edge are settled by the falling edge
        @(negedge clk);
    endtask
    task automatic rreg(input logic [7:0] a);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd   <= 1'b0;
        @(negedge clk);
        d = rdat;
    endtask
    task automatic rchk(input string n, input logic [7:0] a, m, e);
        rreg(a);
        chk(n, e, d & m);
    endtask
    // polls status; bounded so a stuck sequencer cannot hang the run
    task automatic wait_st(input logic [7:0] m, input logic [7:0] e, input int lim);
        int n;
        n = 0;
        rreg(OFS_STATE);
        while ((d & m) !== e && n < lim) begin
            n++;
            rreg(OFS_STATE);
        end
        chk("status", e, d & m);
    endtask
    task automatic settle();
        repeat (5) @(negedge clk);
    endtask
    task automatic t_reset();
        rchk("early", OFS_STATE, 8'h03, 8'h00);
        rchk("cfg0", OFS_CFG_ZERO, 8'hff, 8'h01);
        rchk("cfg1", OFS_CFG_ONE, 8'hff, 8'h01);
        rchk("avg", OFS_AVG, 8'hff, 8'h61);
        rchk("enable", OFS_CAL_ENABLE, 8'hff, 8'h01);
        chk("depths", 8'h61, {1'b0, os_d, 1'b0, lin_d});
        wait_st(8'h03, 8'h03, 40);
        chk("pin done", 8'h01, {7'h0, pin});
    endtask
    task automatic t_fg();
        wreg(OFS_AVG, 8'h35);
        chk("depths w", 8'h35, {1'b0, os_d, 1'b0, lin_d});
        rchk("avg rb", OFS_AVG, 8'hff, 8'h35);
        wreg(OFS_AVG, 8'h11);
        wreg(OFS_CFG_ZERO, 8'h01);
        rchk("cleared", OFS_STATE, 8'h03, 8'h00);
        chk("running", 8'h01, {7'h0, run});
        wait_st(8'h03, 8'h03, 40);
        wreg(OFS_CFG_ZERO, 8'h05);
        repeat (45) @(negedge clk);
        rchk("ofs run", OFS_STATE, 8'h03, 8'h00);
        wait_st(8'h03, 8'h03, 40);
        wreg(OFS_CFG_ZERO, 8'h00);
        wait_st(8'h03, 8'h03, 2);
        rreg(OFS_STATE);
        wreg(OFS_STATE, ~d);
        rchk("ro", OFS_STATE, 8'hff, d);
        rchk("unmapped", 8'h00, 8'hff, 8'h00);
    endtask
    task automatic t_bg();
        logic [3:0] exp;
        exp = 4'b0101;
        wreg(OFS_CAL_ENABLE, 8'h00);
        rchk("held", OFS_STATE, 8'h03, 8'h00);
        chk("held run", 8'h00, {7'h0, run});
        wreg(OFS_CFG_ZERO, 8'h0b);
        wreg(OFS_CFG_ONE, 8'h05);
        chk("offset_reference_select", 8'h01, {7'h0, offset_reference_select});
        wreg(OFS_CAL_ENABLE, 8'h01);
        wait_st(8'h1f, 8'h11, 60);
        wreg(OFS_STOP_REQ, 8'h01);
        wait_st(8'h1f, 8'h17, 60);
        wreg(OFS_STOP_REQ, 8'h00);
        wait_st(8'h03, 8'h01, 5);
        @(posedge clk);
        alarm <= 1'b1;
        for (int s = 0; s < 4; s++) begin
            wreg(OFS_PIN_CFG, 8'(s << 1));
            settle();
            chk("pin", {7'h0, exp[s]}, {7'h0, pin});
        end
        @(posedge clk);
        alarm <= 1'b0;
        wreg(OFS_PIN_CFG, 8'h04);
        settle();
        chk("pin alarm", 8'h00, {7'h0, pin});
        // offset reference back to mid-code before background goes off
        wreg(OFS_CAL_ENABLE, 8'h00);
        wreg(OFS_CFG_ONE, 8'h01);
        chk("offset_reference_select 0", 8'h00, {7'h0, offset_reference_select});
        wreg(OFS_CFG_ZERO, 8'h00);
        wreg(OFS_CAL_ENABLE, 8'h01);
    endtask
    task automatic t_irq();
        wreg(OFS_IRQ_ENABLE, 8'h00);
        wreg(OFS_IRQ_CLEAR, 8'h03);
        // a fresh run raises both events again after the clear
        wreg(OFS_CFG_ZERO, 8'h00);
        wait_st(8'h03, 8'h03, 5);
        rchk("irq st", OFS_IRQ_STATUS, 8'h03, 8'h03);
        chk("irq masked", 8'h00, {7'h0, irq});
        wreg(OFS_IRQ_ENABLE, 8'h01);
        settle();
        chk("irq on", 8'h01, {7'h0, irq});
        wreg(OFS_IRQ_CLEAR, 8'h01);
        settle();
        chk("irq off", 8'h00, {7'h0, irq});
        rchk("irq st2", OFS_IRQ_STATUS, 8'h03, 8'h02);
    endtask
    task automatic stop_test();
        $display("checks %0d errors %0d", checks, err_count);
        if (err_count == 0 && checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    initial begin
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        t_reset();
        t_fg();
        t_bg();
        t_irq();
        stop_test();
    end
    // the sequence needs under a thousand cycles; allow ample margin
    initial begin
        #200000;
        err_count++;
        stop_test();
    end
endmodule
`default_nettype wire
